/* rtl/count_prescaler.sv */
// count clock prescaler: tick every 2, 4, 16 or 256 system clocks
`timescale 1ns/1ps
module count_prescaler #(
  parameter int width = frt_pkg::prescale_width
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] clock_sel,
  output logic            tick,
  output logic            half_phase
);
  import frt_pkg::*;
  logic [width-1:0] divider;
  logic [width-1:0] period_mask;

  // elaboration check: the divide by 256 needs eight divider bits
  if (width < 8) begin : g_width_check
    $error("prescaler width too small for divide by 256");
  end

  // ---------------------------------------------------------------------
  // divide selection
  // ---------------------------------------------------------------------
  always_comb begin
    case (clock_sel)
      2'b00:   period_mask = width'(8'h01);
      2'b01:   period_mask = width'(8'h03);
      2'b10:   period_mask = width'(8'h0f);
      default: period_mask = width'(8'hff);
    endcase
  end

  // free running divider chain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      divider <= '0;
    end else begin
      divider <= divider + width'(1);
    end
  end

  // one tick per selected period; half_phase marks the period's first half
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick       <= 1'b0;
      half_phase <= 1'b0;
    end else begin
      tick       <= ((divider & period_mask) == period_mask);
      half_phase <= ((divider & period_mask) <= (period_mask >> 1));
    end
  end
endmodule // count_prescaler

/* rtl/free_run_timer_capture_compare.sv */
// top: 16-bit free running timer with compare, capture and read buffer
// Summary of operation
// - counter wrap sets overflow flag; cleared by reset or written zero
// - capture edge code 00 off, 01 rising, 10 falling, 11 both edges
// - count clock is system clock over 2, 4, 16 or 256
// - reset loads the port 2 direction register with all ones
// - counter equal to compare raises match request, counter keeps running
// - match interval is 65536 count clock periods
// - capture register loads count within two clocks, holds to next edge
// - low byte read freezes the read buffer; reads return frozen value
// - end of high byte read releases the buffer to track again
// - reset clears the counter to zero and counting restarts itself
// - byte reads go low then high; lone high read is undefined
// - count after stop release is undefined since counting continues
// - mask the compare interrupt before rewriting the compare value
// - match signal stays high half a count clock period after a match
// - reset sets compare to all ones, mode control to zero
`timescale 1ns/1ps
module free_run_timer_capture_compare (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] write_data,
  input  wire logic        write_strobe,
  input  wire logic        word_access,
  input  wire logic        read_strobe,
  input  wire logic        cpu_clock_fall,
  input  wire logic        port2_bit4_pin,
  output logic      [15:0] read_data,
  output logic             compare_match_irq,
  output logic      [7:0]  port2_direction,
  output logic             trigger_pin_direction_bit
);
  import frt_pkg::*;

  // ---------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------
  logic        rst_meta_b;
  logic        rst_sync_b;
  logic [15:0] free_running_count;
  logic [15:0] compare_value;
  logic [15:0] capture_value;
  logic [7:0]  timer_mode_control;
  logic [15:0] read_buffer;
  logic        buffer_frozen;
  logic        low_read_seen;
  logic        high_read_seen;
  logic        pin_last;
  logic        capture_fire;
  logic        tick;
  logic        half_phase;
  logic        match_hold;
  logic        rise_seen;
  logic        fall_seen;
  logic        edge_hit;
  logic        wr_mode;
  logic        wr_cmp_lo;
  logic        wr_cmp_hi;
  logic        wr_dir;
  logic        rd_count_lo;
  logic        rd_count_hi;
  logic        wrap;
  logic [15:0] next_read_data;
  edge_sel_type edge_sel;

  // ---------------------------------------------------------------------
  // reset release through two flip-flops
  // ---------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ---------------------------------------------------------------------
  // prescaler
  // ---------------------------------------------------------------------
  count_prescaler #(
    .width (prescale_width)
  ) u_prescaler (
    .clk        (clk),
    .rst_b      (rst_sync_b),
    .clock_sel  (timer_mode_control[count_clock_hi:count_clock_lo]),
    .tick       (tick),
    .half_phase (half_phase)
  );

  // ---------------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------------
  assign wr_mode     = write_strobe && (addr == timer_mode_control_addr);
  assign wr_cmp_lo   = write_strobe && (addr == compare_value_low_addr);
  assign wr_cmp_hi   = write_strobe && ((addr == compare_value_high_addr) ||
                       (word_access && addr == compare_value_low_addr));
  assign wr_dir      = write_strobe && (addr == port2_direction_addr);
  assign rd_count_lo = read_strobe && (addr == count_low_addr);
  assign rd_count_hi = read_strobe && ((addr == count_high_addr) ||
                       (word_access && addr == count_low_addr));
  assign wrap        = tick && (free_running_count == 16'hffff);
  assign edge_sel    = edge_sel_type'(
                       timer_mode_control[capture_edge_hi:capture_edge_lo]);

  // ---------------------------------------------------------------------
  // free running counter
  // ---------------------------------------------------------------------
  // counts on every tick, never cleared by a match
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      free_running_count <= count_reset;
    end else if (tick) begin
      free_running_count <= free_running_count + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------
  // mode control register with overflow flag
  // ---------------------------------------------------------------------
  // bits 0, 3 and 7 are kept zero; overflow set wins over a written zero
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      timer_mode_control <= mode_reset;
    end else begin
      if (wr_mode) begin
        timer_mode_control <= write_data[7:0] & mode_writable_mask;
      end
      if (wrap) begin
        timer_mode_control[overflow_bit] <= 1'b1;
      end else if (wr_mode) begin
        // a written one leaves the flag as it is, a written zero clears it
        timer_mode_control[overflow_bit] <=
          timer_mode_control[overflow_bit] & write_data[overflow_bit];
      end
    end
  end

  // ---------------------------------------------------------------------
  // compare register
  // ---------------------------------------------------------------------
  // low byte, high byte, or both at once on a word write
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      compare_value <= compare_reset;
    end else begin
      if (wr_cmp_lo) begin
        compare_value[7:0] <= write_data[7:0];
      end
      if (wr_cmp_hi) begin
        compare_value[15:8] <= word_access ? write_data[15:8]
                                           : write_data[7:0];
      end
    end
  end

  // ---------------------------------------------------------------------
  // compare match request
  // ---------------------------------------------------------------------
  // held from the match until the count clock's half period elapses
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      match_hold        <= 1'b0;
      compare_match_irq <= 1'b0;
    end else begin
      if (free_running_count == compare_value && half_phase) begin
        match_hold <= 1'b1;
      end else begin
        match_hold <= 1'b0;
      end
      compare_match_irq <= match_hold;
    end
  end

  // ---------------------------------------------------------------------
  // capture edge detection
  // ---------------------------------------------------------------------
  // edges seen against the previous pin sample
  assign rise_seen = port2_bit4_pin && !pin_last;
  assign fall_seen = !port2_bit4_pin && pin_last;

  // decode of the capture edge code
  always_comb begin
    case (edge_sel)
      edge_none:    edge_hit = 1'b0;
      edge_rising:  edge_hit = rise_seen;
      edge_falling: edge_hit = fall_seen;
      edge_both:    edge_hit = rise_seen | fall_seen;
      default:      edge_hit = 1'b0;
    endcase
  end

  // pin history and capture strobe, gated by input mode of the pin
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      pin_last     <= 1'b0;
      capture_fire <= 1'b0;
    end else begin
      pin_last     <= port2_bit4_pin;
      capture_fire <= edge_hit && trigger_pin_direction_bit;
    end
  end

  // capture register is undefined after reset, so it carries no reset
  always_ff @(posedge clk) begin
    if (capture_fire) begin
      capture_value <= free_running_count;
    end
  end

  // ---------------------------------------------------------------------
  // counter read buffer
  // ---------------------------------------------------------------------
  // strobe seen latches are consumed at the next cpu clock fall
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      low_read_seen  <= 1'b0;
      high_read_seen <= 1'b0;
      buffer_frozen  <= 1'b0;
    end else begin
      if (rd_count_lo) begin
        low_read_seen <= 1'b1;
      end else if (cpu_clock_fall) begin
        low_read_seen <= 1'b0;
      end
      if (rd_count_hi) begin
        high_read_seen <= 1'b1;
      end else if (cpu_clock_fall) begin
        high_read_seen <= 1'b0;
      end
      if (cpu_clock_fall && high_read_seen && !rd_count_hi) begin
        buffer_frozen <= 1'b0;
      end else if (cpu_clock_fall && low_read_seen) begin
        buffer_frozen <= 1'b1;
      end
    end
  end

  // buffer tracks the count unless frozen or freezing this cycle
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      read_buffer <= count_reset;
    end else if (!buffer_frozen && !(cpu_clock_fall && low_read_seen)) begin
      read_buffer <= free_running_count;
    end
  end

  // ---------------------------------------------------------------------
  // port 2 direction register
  // ---------------------------------------------------------------------
  // direction register; bit 4 also gates the capture trigger
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      port2_direction           <= direction_reset;
      trigger_pin_direction_bit <= 1'b1;
    end else if (wr_dir) begin
      port2_direction           <= write_data[7:0];
      trigger_pin_direction_bit <= write_data[trigger_bit];
    end
  end

  // ---------------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------------
  // read mux; unmapped addresses read as zero
  always_comb begin
    next_read_data = 16'h0000;
    case (addr)
      count_low_addr: begin
        next_read_data = word_access ? read_buffer
                                     : {8'h00, read_buffer[7:0]};
      end
      count_high_addr:         next_read_data = {8'h00, read_buffer[15:8]};
      compare_value_low_addr: begin
        next_read_data = word_access ? compare_value
                                     : {8'h00, compare_value[7:0]};
      end
      compare_value_high_addr: next_read_data = {8'h00, compare_value[15:8]};
      capture_low_addr: begin
        next_read_data = word_access ? capture_value
                                     : {8'h00, capture_value[7:0]};
      end
      capture_high_addr:       next_read_data = {8'h00, capture_value[15:8]};
      timer_mode_control_addr: next_read_data = {8'h00, timer_mode_control};
      port2_direction_addr:    next_read_data = {8'h00, port2_direction};
      default:                 next_read_data = 16'h0000;
    endcase
  end

  // registered read data
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      read_data <= 16'h0000;
    end else if (read_strobe) begin
      read_data <= next_read_data;
    end
  end
endmodule // free_run_timer_capture_compare

/* rtl/frt_pkg.sv */
// package: register map, field layout and reset values of the 16-bit timer
package frt_pkg;
  // -------------------------------------------------------------------
  // register byte addresses
  // -------------------------------------------------------------------
  localparam logic [15:0] compare_value_low_addr  = 16'hff16;
  localparam logic [15:0] compare_value_high_addr = 16'hff17;
  localparam logic [15:0] port2_direction_addr    = 16'hff22;
  localparam logic [15:0] timer_mode_control_addr = 16'hff48;
  localparam logic [15:0] count_low_addr          = 16'hff18;
  localparam logic [15:0] count_high_addr         = 16'hff19;
  localparam logic [15:0] capture_low_addr        = 16'hff1a;
  localparam logic [15:0] capture_high_addr       = 16'hff1b;
  // -------------------------------------------------------------------
  // mode control field positions
  // -------------------------------------------------------------------
  localparam int overflow_bit       = 6;
  localparam int capture_edge_hi    = 5;
  localparam int capture_edge_lo    = 4;
  localparam int count_clock_hi     = 2;
  localparam int count_clock_lo     = 1;
  localparam logic [7:0] mode_writable_mask = 8'h76;
  // -------------------------------------------------------------------
  // reset values
  // -------------------------------------------------------------------
  localparam logic [15:0] count_reset     = 16'h0000;
  localparam logic [15:0] compare_reset   = 16'hffff;
  localparam logic [7:0]  mode_reset      = 8'h00;
  localparam logic [7:0]  direction_reset = 8'hff;
  localparam int          trigger_bit     = 4;
  // -------------------------------------------------------------------
  // capture edge codes and prescaler width
  // -------------------------------------------------------------------
  typedef enum logic [1:0] {
    edge_none    = 2'b00,
    edge_rising  = 2'b01,
    edge_falling = 2'b10,
    edge_both    = 2'b11
  } edge_sel_type;
  localparam int prescale_width = 8;
endpackage

/* verif/free_run_timer_capture_compare_tb_top.sv */
// testbench: register bus stimulus with queued read checks
`timescale 1ns/1ps
module free_run_timer_capture_compare_tb_top;
  import frt_pkg::*;
  typedef struct {logic [15:0] exp; logic [15:0] mask; bit chk;} note_type;
  logic        clk, rst_b, write_strobe, word_access, read_strobe;
  logic        cpu_clock_fall, compare_match_irq, trigger_pin_direction_bit;
  logic        want, pend, pin;
  logic [15:0] addr, write_data, read_data, got, v0, v1;
  logic [7:0]  port2_direction, rnd;
  logic [3:0]  lag;
  logic [1:0]  ph;
  int          error_cnt, n_tests, t, i;
  int          sh [4] = '{1, 2, 4, 8};
  note_type    notes[$];
  note_type    nt;
  free_run_timer_capture_compare dut (
    .clk(clk), .rst_b(rst_b), .addr(addr), .write_data(write_data),
    .write_strobe(write_strobe), .word_access(word_access),
    .read_strobe(read_strobe), .cpu_clock_fall(cpu_clock_fall),
    .port2_bit4_pin(pin), .read_data(read_data),
    .compare_match_irq(compare_match_irq), .port2_direction(port2_direction),
    .trigger_pin_direction_bit(trigger_pin_direction_bit));
  trigger_model u_trig (.clk(clk), .want(want), .lag(lag), .pin(pin));
  // clock, and a cpu clock falling edge marker every second cycle:
  // the cpu runs at half the system clock, where count reads hold
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    ph <= ph + 2'd1;
    cpu_clock_fall <= ph[0];
  end
  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task automatic span(input string n, input logic [15:0] s, base, lo, hi, m);
    logic [15:0] d;
    d = (s - base) & m;
    n_tests++;
    if ((d >= lo && d <= hi) !== 1'b1) begin
      $display("unexpected %s expected %h+%0d..%0d seen %h", n, base, lo, hi,
               s);
      error_cnt++;
    end
  endtask
  task automatic wr(input logic [15:0] a, d, input logic w);
    @(posedge clk);
    addr <= a;
    write_data <= d;
    word_access <= w;
    write_strobe <= 1'b1;
    @(posedge clk);
    write_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic w,
                    input logic [15:0] e, m, input bit c);
    notes.push_back('{e, m, c});
    @(posedge clk);
    addr <= a;
    word_access <= w;
    read_strobe <= 1'b1;
    @(posedge clk);
    read_strobe <= 1'b0;
    @(negedge clk);
    got = read_data;
  endtask
  // one trigger edge; capture expected only when cap is set
  task automatic edge_step(input logic lvl, input logic cap);
    rd(count_low_addr, 1'b1, 16'h0, 16'h0, 1'b0);
    v1 = got;
    @(posedge clk);
    lag <= 4'($urandom_range(7));
    want <= lvl;
    repeat (14) @(posedge clk);
    rd(capture_low_addr, 1'b1, v0, 16'hffff, !cap);
    if (cap) span("capture", got, v1, 0, 8, 16'hffff);
    v0 = got;
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // result watcher: each read answer is matched to the oldest note
  always @(posedge clk) pend <= read_strobe;
  always @(negedge clk) begin
    if (pend === 1'b1) begin
      nt = notes.pop_front();
      if (nt.chk) span("read_data", read_data, nt.exp, 0, 0, nt.mask);
    end
  end
  // watchdog on a hung run
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    test_done();
  end
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    {rst_b, write_strobe, word_access, read_strobe, want} = 5'h0;
    {addr, write_data, ph, lag} = 38'h0;
    error_cnt = 0;
    n_tests = 0;
    void'($urandom(55));
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
    rd(count_low_addr, 1'b1, 16'h0, 16'h0, 1'b0);
    span("count", got, 16'h0000, 0, 16, 16'hffff);
    rd(compare_value_low_addr, 1'b1, 16'hffff, 16'hffff, 1'b1);
    rd(timer_mode_control_addr, 1'b0, 16'h0000, 16'h00ff, 1'b1);
    rd(port2_direction_addr, 1'b0, 16'h00ff, 16'h00ff, 1'b1);
    wr(timer_mode_control_addr, 16'h00bf, 1'b0);
    rd(timer_mode_control_addr, 1'b0, 16'h0036, 16'h00ff, 1'b1);
    wr(16'hff30, 16'h1234, 1'b1);
    rd(16'hff30, 1'b1, 16'h0000, 16'hffff, 1'b1);
    rnd = 8'($urandom);
    wr(port2_direction_addr, {8'h00, rnd}, 1'b0);
    rd(port2_direction_addr, 1'b0, {8'h00, rnd}, 16'h00ff, 1'b1);
    span("direction", {8'h00, port2_direction}, {8'h00, rnd}, 0, 0, 16'hff);
    v0 = 16'($urandom);
    wr(compare_value_low_addr, v0, 1'b1);
    rd(compare_value_low_addr, 1'b1, v0, 16'hffff, 1'b1);
    v0 = 16'($urandom);
    wr(compare_value_high_addr, {8'h00, v0[15:8]}, 1'b0);
    wr(compare_value_low_addr, {8'h00, v0[7:0]}, 1'b0);
    rd(compare_value_low_addr, 1'b1, v0, 16'hffff, 1'b1);
    // each count clock code: progress over 512 system clocks
    for (i = 0; i < 4; i++) begin
      wr(timer_mode_control_addr, 16'(i << 1), 1'b0);
      rd(count_low_addr, 1'b1, 16'h0, 16'h0, 1'b0);
      v0 = got;
      repeat (512) @(posedge clk);
      rd(count_low_addr, 1'b1, 16'h0, 16'h0, 1'b0);
      span("rate", got, v0, (512 >> sh[i]) - 1,
           (530 >> sh[i]) + 1, 16'hffff);
    end
    // lone low byte reads stay frozen until a high byte read
    wr(timer_mode_control_addr, 16'h0000, 1'b0);
    rd(count_low_addr, 1'b0, 16'h0, 16'h0, 1'b0);
    v0 = got;
    repeat (100) @(posedge clk);
    rd(count_low_addr, 1'b0, 16'h0, 16'h0, 1'b0);
    span("frozen", got, v0, 0, 3, 16'h00ff);
    rd(count_high_addr, 1'b0, 16'h0, 16'h0, 1'b0);
    repeat (20) @(posedge clk);
    rd(count_low_addr, 1'b0, 16'h0, 16'h0, 1'b0);
    span("released", got, v0, 50, 80, 16'h00ff);
    // match request with the counter running on
    rd(count_low_addr, 1'b1, 16'h0, 16'h0, 1'b0);
    v0 = got;
    wr(compare_value_low_addr, v0 + 16'h0028, 1'b1);
    t = 0;
    while (compare_match_irq !== 1'b1 && t < 300) begin
      @(posedge clk);
      t++;
    end
    span("match", 16'(t), 16'h0000, 60, 90, 16'hffff);
    rd(count_low_addr, 1'b1, 16'h0, 16'h0, 1'b0);
    span("count", got, v0, 41, 80, 16'hffff);
    // capture edge codes, then gated off by output direction
    wr(port2_direction_addr, 16'h00ff, 1'b0);
    wr(timer_mode_control_addr, 16'h0030, 1'b0);
    edge_step(1'b1, 1'b1);
    for (i = 0; i < 4; i++) begin
      wr(timer_mode_control_addr, 16'(i << 4), 1'b0);
      edge_step(1'b0, i[1]);
      edge_step(1'b1, i[0]);
    end
    wr(port2_direction_addr, 16'h00ef, 1'b0);
    wr(timer_mode_control_addr, 16'h0030, 1'b0);
    edge_step(1'b0, 1'b0);
    test_done();
  end
endmodule // free_run_timer_capture_compare_tb_top

/* verif/frt_chk.sv */
// checker: port level relations of the 16-bit timer
`timescale 1ns/1ps
module frt_chk (
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic [15:0] addr,
  input wire logic [15:0] write_data,
  input wire logic        write_strobe,
  input wire logic        word_access,
  input wire logic        read_strobe,
  input wire logic [15:0] read_data,
  input wire logic        compare_match_irq,
  input wire logic [7:0]  port2_direction,
  input wire logic        trigger_pin_direction_bit
);
  import frt_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // match pulse: rise, then drop within half the slowest count period
  sequence irq_start;
    $rose(compare_match_irq);
  endsequence
  sequence irq_end;
    ##[1:129] !compare_match_irq;
  endsequence
  chk_irq_width: assert property (irq_start |-> irq_end)
    else $error("match request held too long");
  chk_dir_reset: assert property ($rose(rst_b) |->
    (port2_direction == 8'hff && trigger_pin_direction_bit) [*3])
    else $error("direction not all ones after reset");
  chk_reset_quiet: assert property ($rose(rst_b) |->
    (!compare_match_irq && read_data == 16'h0000) [*3])
    else $error("outputs not quiet after reset");
  chk_dir_copy: assert property (
    trigger_pin_direction_bit == port2_direction[trigger_bit])
    else $error("trigger direction bit lost its source");
  chk_dir_write: assert property (write_strobe && !word_access &&
    addr == port2_direction_addr |=>
    port2_direction == $past(write_data[7:0]))
    else $error("direction write not taken");
  chk_mode_zeros: assert property (
    read_strobe && addr == timer_mode_control_addr |=>
    (read_data[7] | read_data[3] | read_data[0]) == 1'b0)
    else $error("mode fixed bits not zero");
  chk_read_hold: assert property (!read_strobe |=>
    $stable(read_data))
    else $error("read data moved without a read");
  chk_dir_readback: assert property (
    read_strobe && addr == port2_direction_addr |=>
    read_data[7:0] == $past(port2_direction))
    else $error("direction readback differs");
endmodule // frt_chk
bind free_run_timer_capture_compare frt_chk u_frt_chk (
  .clk(clk), .rst_b(rst_b), .addr(addr), .write_data(write_data),
  .write_strobe(write_strobe), .word_access(word_access),
  .read_strobe(read_strobe), .read_data(read_data),
  .compare_match_irq(compare_match_irq), .port2_direction(port2_direction),
  .trigger_pin_direction_bit(trigger_pin_direction_bit)
);

/* verif/trigger_model.sv */
// far side model: external source driving the capture trigger pin
`timescale 1ns/1ps
module trigger_model (
  input  wire logic       clk,
  input  wire logic       want,
  input  wire logic [3:0] lag,
  output logic            pin
);
  logic [3:0] wait_cnt;
  initial pin = 1'b0;
  initial wait_cnt = 4'h0;
  // pin follows the wanted level after lag cycles, prompt or slow
  always @(posedge clk) begin
    if (pin == want) begin
      wait_cnt <= 4'h0;
    end else if (wait_cnt >= lag) begin
      pin <= want;
    end else begin
      wait_cnt <= wait_cnt + 4'h1;
    end
  end
endmodule // trigger_model
